/* File: logic/sysctl_pkg.sv */
// Contract
// - four operating modes plus transient power-on
// - hold power-on about three seconds, then low
// - after reset pll off, slow clock only
// - cpu first runs in low-speed mode
// - high-speed uses pll clock, software entered
// - halt in low-speed enters low halt
// - low halt stops io clocks per settings
// - unmasked interrupt wakes low halt to low
// - gpio, external pin, slow timer wake
// - halt in high-speed enters high halt
// - high halt applies all stops together
// - unmasked interrupt returns high halt to high
// - cpu, ahb, apb rates switch at runtime
// - one clock gate per peripheral
// - separate clock divider per uart
// - static input picks resonator or oscillator
// - decode block at base ffff_d000
// - pll parameters writable only while pll off
package sysctl_pkg;
	localparam logic [31:0] SYS_BASE = 32'hffff_d000;
	localparam logic [11:0] OFS_CHIP_IDENTIFICATION = 12'h000;
	localparam logic [11:0] OFS_STRAP_CONFIGURATION = 12'h004;
	localparam logic [11:0] OFS_PLL_PARAMETERS = 12'h008;
	localparam logic [11:0] OFS_PLL_POWER_CONTROL = 12'h00c;
	localparam logic [11:0] OFS_HALT_CLOCK_GATING = 12'h010;
	localparam logic [11:0] OFS_PERIPHERAL_CLOCK_GATING = 12'h014;
	localparam logic [11:0] OFS_CLOCK_SOURCE_SELECT = 12'h018;
	localparam logic [11:0] OFS_HALT_TRIGGER = 12'h01c;
	localparam logic [11:0] OFS_ADDRESS_MAP_SWAP = 12'h020;
	localparam logic [11:0] OFS_SOFTWARE_RESET_TRIGGER = 12'h024;
	localparam logic [11:0] OFS_UART1_BAUD_DIVIDER = 12'h028;
	localparam logic [11:0] OFS_UART2_BAUD_DIVIDER = 12'h02c;
	localparam logic [11:0] OFS_UART3_BAUD_DIVIDER = 12'h030;
	localparam logic [11:0] OFS_SECOND_TIMER_CLOCK_SELECT = 12'h034;
	localparam logic [11:0] OFS_MEMORY_BUS_PULLDOWN = 12'h040;
	localparam logic [11:0] OFS_CARD_BUS_PULLDOWN = 12'h044;
	localparam logic [11:0] OFS_PORT_E_RESISTORS = 12'h048;
	localparam logic [11:0] OFS_PORT_F_RESISTORS = 12'h04c;
	localparam logic [11:0] OFS_PORT_G_RESISTORS = 12'h050;
	localparam logic [11:0] OFS_PORT_H_RESISTORS = 12'h054;
	localparam logic [11:0] OFS_PORT_I_RESISTORS = 12'h058;
	localparam logic [11:0] OFS_PORT_J_RESISTORS = 12'h05c;
	localparam logic [11:0] OFS_PORT_K_RESISTORS = 12'h060;
	localparam logic [11:0] OFS_INTERNAL_TEST_SELECT = 12'h064;
	localparam logic [11:0] OFS_ON_CHIP_RAM_CONTROL = 12'h068;
	localparam logic [11:0] OFS_GENERAL_EXTRA_SETTINGS = 12'h06c;
	localparam int unsigned REG_WORDS = 28;
	// reset values
	localparam logic [31:0] RST_PLL_PARAMETERS = 32'h0421_84ae;
	localparam logic [31:0] RST_CLEAR = 32'h0000_0000;
	// arbitrary neutral identity value
	localparam logic [31:0] CHIP_ID_DEFAULT = 32'h0000_0001;
	// field positions
	localparam int unsigned PLL_RUN_BIT_POS = 0;
	localparam int unsigned HIGH_REQ_POS = 0;
	localparam int unsigned CPU_DIV_LSB = 4;
	localparam int unsigned AHB_DIV_LSB = 8;
	localparam int unsigned APB_DIV_LSB = 12;
	localparam int unsigned MODE_STAT_LSB = 16;
	localparam int unsigned HALT_CPU_STOP_POS = 0;
	localparam int unsigned HALT_AHB_STOP_POS = 1;
	localparam int unsigned HALT_APB_STOP_POS = 2;
	localparam int unsigned HALT_IO_STOP_POS = 3;
	localparam int unsigned SWRST_POS = 0;
	localparam int unsigned REMAP_POS = 0;
	localparam int unsigned UART_DIV_W = 16;
	// timing
	localparam int unsigned CLK_KHZ = 125000;
	localparam int unsigned POWER_ON_MS = 3000;
	localparam int unsigned PON_CYCLES = POWER_ON_MS * CLK_KHZ;
	typedef enum logic [2:0] {
		MODE_POWER_ON,
		MODE_LOW,
		MODE_LOW_HALT,
		MODE_HIGH,
		MODE_HIGH_HALT
	} mode_e;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_s;
endpackage : sysctl_pkg

/* File: logic/system_clock_power_mode_ctrl.sv */
`timescale 1ns/1ps
module system_clock_power_mode_ctrl #(
	parameter int unsigned POWER_ON_CYCLES = sysctl_pkg::PON_CYCLES,
	parameter int unsigned NUM_PERIPH = 32,
	parameter logic [31:0] CHIP_ID = sysctl_pkg::CHIP_ID_DEFAULT
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// peripheral bus
	input wire sysctl_pkg::apb_req_s bus_req,
	output sysctl_pkg::apb_rsp_s bus_rsp,
	// pins
	input wire logic slow_clock_pin,
	input wire logic slow_clock_source_select,
	input wire logic ext_irq_pin,
	input wire logic [15:0] strap_pins,
	// wake sources
	input wire logic irq_unmasked,
	input wire logic gpio_irq,
	input wire logic slow_timer_irq,
	// clock enables
	output logic cpu_clk_en,
	output logic ahb_clk_en,
	output logic apb_clk_en,
	output logic [NUM_PERIPH-1:0] periph_clk_en,
	output logic [2:0] uart_clk_en,
	// control outputs
	output logic osc_amp_en,
	output logic pll_power_down,
	output logic [31:0] pll_params,
	output logic address_swap,
	output logic sw_reset,
	output sysctl_pkg::mode_e mode
);
	import sysctl_pkg::*;

	mode_e mode_r;
	logic [31:0] store_r [0:REG_WORDS-1];
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic [31:0] pon_cnt_r;
	logic [15:0] strap_r;
	logic [15:0] strap_s1_r;
	logic [15:0] strap_s2_r;
	logic [15:0] strap_s3_r;
	logic [3:0] strap_wait_r;
	logic [3:0] halt_stops_r;
	logic sw_reset_r;
	logic [2:0] slow_sync_r;
	logic slow_lvl_r;
	logic [2:0] ext_sync_r;
	logic ext_lvl_r;
	logic [2:0] sel_sync_r;
	logic sel_lvl_r;
	logic [11:0] ofs;
	logic [4:0] widx;
	logic in_block;
	logic mapped;
	logic writable;
	logic wr;
	logic rd_setup;
	logic slow_tick;
	logic base_en;
	logic running;
	logic halting;
	logic io_stop;
	logic halt_cmd;
	logic wake;
	logic pll_run;
	logic high_req;
	logic [2:0] bus_en;
	logic [31:0] rd_val;

	function automatic logic [2:0] div_mask(input logic [1:0] sel);
		logic [2:0] m;
		m = 3'h0;
		case (sel)
			2'h1: m = 3'h1;
			2'h2: m = 3'h3;
			2'h3: m = 3'h7;
			default: m = 3'h0;
		endcase
		return m;
	endfunction : div_mask

	// address decode
	assign ofs = bus_req.paddr[11:0];
	assign widx = bus_req.paddr[6:2];
	assign in_block = (bus_req.paddr[31:12] == SYS_BASE[31:12]) && (ofs[1:0] == 2'h0);

	always_comb begin
		mapped = 1'b1;
		writable = 1'b1;
		case (ofs)
			OFS_CHIP_IDENTIFICATION, OFS_STRAP_CONFIGURATION: writable = 1'b0;
			OFS_HALT_TRIGGER, OFS_SOFTWARE_RESET_TRIGGER: writable = 1'b0;
			OFS_PLL_PARAMETERS, OFS_PLL_POWER_CONTROL, OFS_HALT_CLOCK_GATING: ;
			OFS_PERIPHERAL_CLOCK_GATING, OFS_CLOCK_SOURCE_SELECT: ;
			OFS_ADDRESS_MAP_SWAP, OFS_UART1_BAUD_DIVIDER: ;
			OFS_UART2_BAUD_DIVIDER, OFS_UART3_BAUD_DIVIDER: ;
			OFS_SECOND_TIMER_CLOCK_SELECT, OFS_MEMORY_BUS_PULLDOWN: ;
			OFS_CARD_BUS_PULLDOWN, OFS_PORT_E_RESISTORS, OFS_PORT_F_RESISTORS: ;
			OFS_PORT_G_RESISTORS, OFS_PORT_H_RESISTORS, OFS_PORT_I_RESISTORS: ;
			OFS_PORT_J_RESISTORS, OFS_PORT_K_RESISTORS, OFS_INTERNAL_TEST_SELECT: ;
			OFS_ON_CHIP_RAM_CONTROL, OFS_GENERAL_EXTRA_SETTINGS: ;
			default: begin
				mapped = 1'b0;
				writable = 1'b0;
			end
		endcase
		if (!in_block) begin
			mapped = 1'b0;
			writable = 1'b0;
		end
	end

	// ready is always high, so the access phase lasts one cycle
	assign wr = bus_req.psel && bus_req.penable && bus_req.pwrite;
	assign rd_setup = bus_req.psel && !bus_req.penable && !bus_req.pwrite;
	assign halt_cmd = wr && in_block && (ofs == OFS_HALT_TRIGGER);
	assign pll_run = store_r[OFS_PLL_POWER_CONTROL[6:2]][PLL_RUN_BIT_POS];
	assign high_req = store_r[OFS_CLOCK_SOURCE_SELECT[6:2]][HIGH_REQ_POS];

	// register storage
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < REG_WORDS; i++) begin
				store_r[i] <= RST_CLEAR;
			end
			store_r[OFS_PLL_PARAMETERS[6:2]] <= RST_PLL_PARAMETERS;
		end else if (wr && writable) begin
			if (ofs == OFS_PLL_PARAMETERS) begin
				// silently dropped while the pll runs
				if (!pll_run) begin
					store_r[widx] <= bus_req.pwdata;
				end
			end else begin
				store_r[widx] <= bus_req.pwdata;
			end
		end
	end

	// read data captured in the setup phase
	always_comb begin
		rd_val = 32'h0;
		case (ofs)
			OFS_CHIP_IDENTIFICATION: rd_val = CHIP_ID;
			OFS_STRAP_CONFIGURATION: rd_val = {16'h0, strap_r};
			OFS_HALT_TRIGGER, OFS_SOFTWARE_RESET_TRIGGER: rd_val = 32'h0;
			OFS_CLOCK_SOURCE_SELECT: begin
				rd_val = store_r[widx];
				rd_val[MODE_STAT_LSB+2:MODE_STAT_LSB] = mode_r;
			end
			default: rd_val = store_r[widx];
		endcase
		if (!mapped) begin
			rd_val = 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			prdata_r <= 32'h0;
		end else if (rd_setup) begin
			prdata_r <= rd_val;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pslverr_r <= 1'b0;
		end else if (bus_req.psel && !bus_req.penable) begin
			pslverr_r <= !mapped;
		end
	end

	assign bus_rsp.pready = 1'b1;
	assign bus_rsp.pslverr = pslverr_r && bus_req.psel && bus_req.penable;
	assign bus_rsp.prdata = prdata_r;

	// software reset pulse, write only
	always_ff @(posedge clk) begin
		if (srst) begin
			sw_reset_r <= 1'b0;
		end else begin
			sw_reset_r <= wr && in_block && (ofs == OFS_SOFTWARE_RESET_TRIGGER)
				&& bus_req.pwdata[SWRST_POS];
		end
	end

	// straps are pins too: three stages, then one capture four edges after release
	always_ff @(posedge clk) begin
		if (srst) begin
			strap_wait_r <= 4'h1;
		end else begin
			strap_wait_r <= {strap_wait_r[2:0], 1'b0};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			strap_s1_r <= 16'h0;
			strap_s2_r <= 16'h0;
			strap_s3_r <= 16'h0;
		end else begin
			strap_s1_r <= strap_pins;
			strap_s2_r <= strap_s1_r;
			strap_s3_r <= strap_s2_r;
		end
	end

	// a strap still moving at the capture edge is missed until the next reset
	always_ff @(posedge clk) begin
		if (srst) begin
			strap_r <= 16'h0;
		end else if (strap_wait_r[3] && (strap_s2_r == strap_s3_r)) begin
			strap_r <= strap_s3_r;
		end
	end

	// pin synchronisers, a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (srst) begin
			slow_sync_r <= 3'h0;
			ext_sync_r <= 3'h0;
			sel_sync_r <= 3'h0;
		end else begin
			slow_sync_r <= {slow_sync_r[1:0], slow_clock_pin};
			ext_sync_r <= {ext_sync_r[1:0], ext_irq_pin};
			sel_sync_r <= {sel_sync_r[1:0], slow_clock_source_select};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			slow_lvl_r <= 1'b0;
			ext_lvl_r <= 1'b0;
			sel_lvl_r <= 1'b0;
		end else begin
			if (slow_sync_r[1] == slow_sync_r[2]) begin
				slow_lvl_r <= slow_sync_r[2];
			end
			if (ext_sync_r[1] == ext_sync_r[2]) begin
				ext_lvl_r <= ext_sync_r[2];
			end
			if (sel_sync_r[1] == sel_sync_r[2]) begin
				sel_lvl_r <= sel_sync_r[2];
			end
		end
	end

	assign slow_tick = (slow_sync_r[1] == slow_sync_r[2]) && slow_sync_r[2] && !slow_lvl_r;
	assign osc_amp_en = !sel_lvl_r;
	assign wake = irq_unmasked || gpio_irq || slow_timer_irq || ext_lvl_r;

	// power-on wait
	always_ff @(posedge clk) begin
		if (srst) begin
			pon_cnt_r <= 32'h0;
		end else if (mode_r == MODE_POWER_ON) begin
			pon_cnt_r <= pon_cnt_r + 32'h1;
		end
	end

	// operating mode sequencer
	always_ff @(posedge clk) begin
		if (srst) begin
			mode_r <= MODE_POWER_ON;
		end else begin
			case (mode_r)
				MODE_POWER_ON: begin
					if (pon_cnt_r == POWER_ON_CYCLES - 1) begin
						mode_r <= MODE_LOW;
					end
				end
				MODE_LOW: begin
					if (halt_cmd) begin
						mode_r <= MODE_LOW_HALT;
					end else if (high_req && pll_run && slow_tick) begin
						mode_r <= MODE_HIGH;
					end
				end
				MODE_LOW_HALT: begin
					if (wake) begin
						mode_r <= MODE_LOW;
					end
				end
				MODE_HIGH: begin
					if (halt_cmd) begin
						mode_r <= MODE_HIGH_HALT;
					end else if ((!high_req || !pll_run) && slow_tick) begin
						mode_r <= MODE_LOW;
					end
				end
				MODE_HIGH_HALT: begin
					if (irq_unmasked) begin
						mode_r <= MODE_HIGH;
					end
				end
				default: mode_r <= MODE_POWER_ON;
			endcase
		end
	end

	assign mode = mode_r;
	// switches happen on a slow edge, so neither source loses part of a phase
	assign base_en = (mode_r == MODE_HIGH || mode_r == MODE_HIGH_HALT) ? 1'b1 : slow_tick;
	assign running = (mode_r != MODE_POWER_ON);
	assign halting = (mode_r == MODE_LOW_HALT) || (mode_r == MODE_HIGH_HALT);
	// stops frozen at halt entry, so all act in the same cycle and a
	// write during halt cannot stagger them
	always_ff @(posedge clk) begin
		if (srst) begin
			halt_stops_r <= 4'h0;
		end else if (halt_cmd && (mode_r == MODE_LOW || mode_r == MODE_HIGH)) begin
			halt_stops_r <= store_r[OFS_HALT_CLOCK_GATING[6:2]][HALT_IO_STOP_POS:HALT_CPU_STOP_POS];
		end
	end
	assign io_stop = halting && halt_stops_r[HALT_IO_STOP_POS];

	// cpu, ahb and apb dividers, retuned live; a change may clip one period
	generate
		for (genvar g = 0; g < 3; g++) begin : g_bus_div
			localparam int unsigned LSB = (g == 0) ? CPU_DIV_LSB :
				(g == 1) ? AHB_DIV_LSB : APB_DIV_LSB;
			localparam int unsigned STOP = (g == 0) ? HALT_CPU_STOP_POS :
				(g == 1) ? HALT_AHB_STOP_POS : HALT_APB_STOP_POS;
			logic [2:0] cnt_r;
			logic [2:0] mask;
			logic stop;
			assign mask = div_mask(store_r[OFS_CLOCK_SOURCE_SELECT[6:2]][LSB+1:LSB]);
			assign stop = halting && halt_stops_r[STOP];
			always_ff @(posedge clk) begin
				if (srst) begin
					cnt_r <= 3'h0;
				end else if (base_en) begin
					cnt_r <= cnt_r + 3'h1;
				end
			end
			assign bus_en[g] = running && base_en && ((cnt_r & mask) == 3'h0) && !stop;
		end
	endgenerate

	assign cpu_clk_en = bus_en[0];
	assign ahb_clk_en = bus_en[1];
	assign apb_clk_en = bus_en[2];
	assign periph_clk_en = {NUM_PERIPH{bus_en[2] && !io_stop}}
		& store_r[OFS_PERIPHERAL_CLOCK_GATING[6:2]][NUM_PERIPH-1:0];

	// uart baud clock generators
	generate
		for (genvar u = 0; u < 3; u++) begin : g_uart_div
			logic [UART_DIV_W-1:0] cnt_r;
			logic [UART_DIV_W-1:0] div;
			assign div = store_r[OFS_UART1_BAUD_DIVIDER[6:2] + 5'(u)][UART_DIV_W-1:0];
			always_ff @(posedge clk) begin
				if (srst) begin
					cnt_r <= '0;
				end else if (base_en) begin
					if (cnt_r >= div) begin
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
			end
			assign uart_clk_en[u] = running && base_en && (cnt_r >= div) && !io_stop;
		end
	endgenerate

	assign pll_power_down = !pll_run;
	assign pll_params = store_r[OFS_PLL_PARAMETERS[6:2]];
	assign address_swap = store_r[OFS_ADDRESS_MAP_SWAP[6:2]][REMAP_POS];
	assign sw_reset = sw_reset_r;
endmodule : system_clock_power_mode_ctrl

/* File: test/apb_cpu.sv */
`timescale 1ns/1ps
module apb_cpu (
	// clock
	input wire logic clk,
	// bus
	output sysctl_pkg::apb_req_s bus_req,
	input wire sysctl_pkg::apb_rsp_s bus_rsp,
	// status
	output logic stuck
);
	import sysctl_pkg::*;
	initial begin
		bus_req = '0;
		stuck = 1'b0;
	end
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		bus_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		bus_req.penable <= 1'b1;
		@(posedge clk);
		for (n = 0; n < 8 && bus_rsp.pready !== 1'b1; n++)
			@(posedge clk);
		stuck <= (n == 8);
		q = bus_rsp.prdata;
		e = bus_rsp.pslverr;
		// idle bus shows inverted lines, never a stale copy
		bus_req <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
	endtask : xfer
endmodule : apb_cpu

/* File: test/sys_chk_assertions.sv */
`timescale 1ns/1ps
module sys_chk #(
	parameter int unsigned POWER_ON_CYCLES = 20,
	parameter int unsigned NUM_PERIPH = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// bus
	input wire sysctl_pkg::apb_req_s bus_req,
	input wire sysctl_pkg::apb_rsp_s bus_rsp,
	// wake sources
	input wire logic irq_unmasked,
	input wire logic gpio_irq,
	input wire logic slow_timer_irq,
	// outputs
	input wire logic cpu_clk_en,
	input wire logic apb_clk_en,
	input wire logic [NUM_PERIPH-1:0] periph_clk_en,
	input wire logic [31:0] pll_params,
	input wire logic pll_power_down,
	input wire sysctl_pkg::mode_e mode
);
	import sysctl_pkg::*;
	logic [31:0] pon_r;
	logic wr;
	logic halt_w;
	logic pll_w;
	assign wr = bus_req.psel & bus_req.penable & bus_req.pwrite;
	assign halt_w = wr && bus_req.paddr == SYS_BASE + 32'h1c;
	assign pll_w = wr && bus_req.paddr == SYS_BASE + 32'h08;
	// saturates so a long run never wraps back into the power-on window
	always_ff @(posedge clk) pon_r <= srst ? 32'h0 : pon_r + {31'h0, ~&pon_r};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	pon_hold_a: assert property (pon_r < POWER_ON_CYCLES / 2 |-> mode == MODE_POWER_ON)
		else $error("left power-on early");
	pon_end_a: assert property (pon_r == POWER_ON_CYCLES + 4 |-> mode != MODE_POWER_ON)
		else $error("power-on never ended");
	pon_quiet_a: assert property (mode == MODE_POWER_ON |-> !cpu_clk_en && !apb_clk_en)
		else $error("clock enable in power-on");
	low_halt_a: assert property (mode == MODE_LOW && halt_w |=> mode == MODE_LOW_HALT)
		else $error("no low halt entry");
	high_halt_a: assert property (mode == MODE_HIGH && halt_w |=> mode == MODE_HIGH_HALT)
		else $error("no high halt entry");
	low_wake_a: assert property (mode == MODE_LOW_HALT && (irq_unmasked | gpio_irq |
		slow_timer_irq) |=> mode == MODE_LOW)
		else $error("low halt wake wrong");
	high_wake_a: assert property (mode == MODE_HIGH_HALT && irq_unmasked |=> mode == MODE_HIGH)
		else $error("high halt wake wrong");
	high_hold_a: assert property (mode == MODE_HIGH_HALT && !irq_unmasked
		|=> mode == MODE_HIGH_HALT)
		else $error("high halt left alone");
	periph_gate_a: assert property (|periph_clk_en |-> apb_clk_en)
		else $error("peripheral enable without bus enable");
	pll_lock_a: assert property (!pll_power_down && pll_w |=> $stable(pll_params))
		else $error("pll parameters written while running");
	bad_addr_a: assert property (bus_req.psel && bus_req.penable &&
		bus_req.paddr[31:12] != 20'hffffd |-> bus_rsp.pslverr)
		else $error("foreign page not refused");
	cover property (mode == MODE_LOW_HALT);
	cover property (mode == MODE_HIGH_HALT);
	cover property (bus_rsp.pslverr);
endmodule : sys_chk

bind system_clock_power_mode_ctrl sys_chk #(
	.POWER_ON_CYCLES(POWER_ON_CYCLES),
	.NUM_PERIPH(NUM_PERIPH)
) chk (.clk(clk), .srst(srst), .bus_req(bus_req), .bus_rsp(bus_rsp),
	.irq_unmasked(irq_unmasked), .gpio_irq(gpio_irq), .slow_timer_irq(slow_timer_irq),
	.cpu_clk_en(cpu_clk_en), .apb_clk_en(apb_clk_en), .periph_clk_en(periph_clk_en),
	.pll_params(pll_params), .pll_power_down(pll_power_down), .mode(mode));

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import sysctl_pkg::*;
	localparam logic [31:0] B = SYS_BASE;
	typedef struct packed {
		logic [31:0] a, r, d, x;
		logic e;
	} row_s;
	localparam row_s ROWS [10] = '{
		'{B, CHIP_ID_DEFAULT, 32'hffff_ffff, CHIP_ID_DEFAULT, 1'h0},
		'{B + 32'h04, 32'h5a3c, 32'h0, 32'h5a3c, 1'h0},
		'{B + 32'h08, RST_PLL_PARAMETERS, 32'h1234_5678, 32'h1234_5678, 1'h0},
		'{B + 32'h14, 32'h0, 32'hffff_00ff, 32'hffff_00ff, 1'h0},
		'{B + 32'h20, 32'h0, 32'h1, 32'h1, 1'h0},
		'{B + 32'h24, 32'h0, 32'h0, 32'h0, 1'h0},
		'{B + 32'h28, 32'h0, 32'h3, 32'h3, 1'h0},
		'{B + 32'h6c, 32'h0, 32'h5a5a_5a5a, 32'h5a5a_5a5a, 1'h0},
		'{B + 32'h38, 32'h0, 32'hffff_ffff, 32'h0, 1'h1},
		'{32'hffff_e000, 32'h0, 32'hffff_ffff, 32'h0, 1'h1}};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic pin = 1'b0;
	logic sel = 1'b0;
	logic [3:0] src = 4'h0;
	logic [4:0] div_r = 5'h0;
	apb_req_s req;
	apb_rsp_s rsp;
	logic cpu_en, ahb_en, apb_en, amp, pdn, swap, swr, stuck;
	logic [31:0] pen, prm, q;
	logic [2:0] uen;
	logic e;
	mode_e mode;
	int fail_count = 0;
	int n_checks = 0;
	int c;
	always #4 clk = ~clk;
	// slow pin shortened to 32 cycles so halts and switches stay brief
	always @(posedge clk) begin
		div_r <= div_r + 5'h1;
		pin <= div_r[4];
	end
	system_clock_power_mode_ctrl #(.POWER_ON_CYCLES(20)) dut (.clk(clk), .srst(srst),
		.bus_req(req), .bus_rsp(rsp), .slow_clock_pin(pin), .slow_clock_source_select(sel),
		.ext_irq_pin(src[3]), .strap_pins(16'h5a3c), .irq_unmasked(src[2]),
		.gpio_irq(src[0]), .slow_timer_irq(src[1]), .cpu_clk_en(cpu_en),
		.ahb_clk_en(ahb_en), .apb_clk_en(apb_en), .periph_clk_en(pen), .uart_clk_en(uen),
		.osc_amp_en(amp), .pll_power_down(pdn), .pll_params(prm), .address_swap(swap),
		.sw_reset(swr), .mode(mode));
	apb_cpu cpu (.clk(clk), .bus_req(req), .bus_rsp(rsp), .stuck(stuck));
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	task automatic chk_v(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, g, x);
		end
	endtask : chk_v
	task automatic chk_m(input mode_e g, input mode_e x);
		n_checks++;
		if (g !== x) begin
			fail_count++;
			$display("BAD %0t mode %0d want %0d", $time, g, x);
		end
	endtask : chk_m
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		cpu.xfer(1'b1, a, d, q, e);
		@(negedge clk);
	endtask : wr
	task automatic rd(input logic [31:0] a);
		cpu.xfer(1'b0, a, 32'h0, q, e);
		@(negedge clk);
	endtask : rd
	task automatic wait_m(input mode_e m);
		int n;
		for (n = 0; n < 200 && mode !== m; n++)
			@(posedge clk);
		chk_m(mode, m);
		if (n == 200)
			results();
	endtask : wait_m
	// one slow period: 0 peripheral or uart, 1 cpu, 2 ahb, 3 first uart
	task automatic tally(input logic [1:0] s);
		c = 0;
		repeat (32) begin
			@(negedge clk);
			case (s)
				2'h0: c += int'(|{pen, uen});
				2'h1: c += int'(cpu_en);
				2'h2: c += int'(ahb_en);
				default: c += int'(uen[0]);
			endcase
		end
	endtask : tally
	always @(posedge clk) begin
		if (stuck === 1'b1) begin
			fail_count++;
			results();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk_m(mode, MODE_POWER_ON);
		chk_v(32'(pdn), 32'h1);
		repeat (10) @(posedge clk);
		chk_m(mode, MODE_POWER_ON);
		wait_m(MODE_LOW);
		chk_v(32'(amp), 32'h1);
		foreach (ROWS[i]) begin
			rd(ROWS[i].a);
			chk_v(q, ROWS[i].r);
			wr(ROWS[i].a, ROWS[i].d);
			rd(ROWS[i].a);
			chk_v(q, ROWS[i].x);
			chk_v(32'(e), 32'(ROWS[i].e));
		end
		chk_v(32'(swap), 32'h1);
		$display("registers done");
		wr(B + 32'h10, 32'h8);
		for (int i = 0; i < 4; i++) begin
			wr(B + 32'h1c, 32'h0);
			wait_m(MODE_LOW_HALT);
			tally(2'h0);
			chk_v(c, 0);
			@(posedge clk);
			src[i] <= 1'b1;
			wait_m(MODE_LOW);
			src <= 4'h0;
		end
		$display("low halt done");
		wr(B + 32'h0c, 32'h1);
		chk_v(32'(pdn), 32'h0);
		wr(B + 32'h08, 32'h0);
		rd(B + 32'h08);
		chk_v(q, 32'h1234_5678);
		// settling stand-in, scaled with the slow pin
		repeat (40) @(posedge clk);
		wr(B + 32'h18, 32'h1);
		wait_m(MODE_HIGH);
		tally(2'h1);
		chk_v(c, 32);
		tally(2'h2);
		chk_v(c, 32);
		tally(2'h3);
		chk_v(c, 8);
		chk_v(pen, 32'hffff_00ff);
		wr(B + 32'h18, 32'h11);
		tally(2'h1);
		chk_v(c, 16);
		wr(B + 32'h10, 32'h1);
		wr(B + 32'h1c, 32'h0);
		wait_m(MODE_HIGH_HALT);
		@(posedge clk);
		src <= 4'h1;
		tally(2'h1);
		chk_v(c, 0);
		tally(2'h2);
		chk_v(c, 32);
		chk_m(mode, MODE_HIGH_HALT);
		@(posedge clk);
		src <= 4'h4;
		wait_m(MODE_HIGH);
		src <= 4'h0;
		$display("high mode done");
		wr(B + 32'h18, 32'h0);
		wait_m(MODE_LOW);
		wr(B + 32'h0c, 32'h0);
		wr(B + 32'h08, RST_PLL_PARAMETERS);
		chk_v(prm, RST_PLL_PARAMETERS);
		wr(B + 32'h24, 32'h1);
		chk_v(32'(swr), 32'h1);
		@(negedge clk);
		chk_v(32'(swr), 32'h0);
		@(posedge clk);
		sel <= 1'b1;
		repeat (6) @(posedge clk);
		chk_v(32'(amp), 32'h0);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk_m(mode, MODE_POWER_ON);
		chk_v(32'(pdn), 32'h1);
		wait_m(MODE_LOW);
		$display("reset done");
		results();
	end
endmodule : testbench
